/* include/twin_timer_pkg.sv */
// shared constants for the twin threshold timer
package twin_timer_pkg;
   // widths
   localparam int VAL_W = 24;            // present and set value width
   localparam int DIGIT_N = 6;           // number of set value digits
   localparam int ADDR_W = 12;           // decoded register address width
   // time base
   localparam int CLK_HZ = 200_000_000;
   localparam int TICK_HZ = 100;         // timing unit rate, 10 ms
   localparam int TICK_CYC = CLK_HZ / TICK_HZ;
   localparam int POWERUP_MS = 200;      // least power-up settle time
   localparam int POWERUP_TICKS = (POWERUP_MS * TICK_HZ + 999) / 1000;
   localparam int ALT_TICKS = 50;        // alarm code alternation half period
   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_SET1 = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_SET2 = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_PV = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_STAT = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_IRQ = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_MASK = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_CNT = 12'h01C;
   localparam logic [ADDR_W-1:0] OFS_ALARM = 12'h020;
   // control fields
   localparam int CTRL_ABS = 0;          // 1 absolute mode, 0 forecast mode
   localparam int CTRL_DOWN = 1;         // 1 counting down
   localparam int CTRL_PWR_START = 2;    // start timing at power-up
   // status fields
   localparam int ST_FIRST_OUTPUT = 0;
   localparam int ST_SECOND_OUTPUT = 1;
   localparam int ST_RUN = 2;
   localparam int ST_SHOW2 = 3;
   localparam int ST_CPU = 4;
   localparam int ST_RAM = 5;
   localparam int ST_NVM = 6;
   localparam int ST_ALARM = 7;
   localparam int ST_ALARM_SHOW = 8;
   // interrupt event bits
   localparam int IRQ_W = 5;
   localparam int EV_FIRST_OUTPUT = 0;
   localparam int EV_SECOND_OUTPUT = 1;
   localparam int EV_FAULT = 2;
   localparam int EV_ALARM = 3;
   localparam int EV_START = 4;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [VAL_W-1:0] SET1_RST = 24'h000000;
   localparam logic [VAL_W-1:0] SET2_RST = 24'h0003E8;
   localparam logic [31:0] ALARM_RST = 32'h0000_FFFF;
   // display codes
   localparam logic [2:0] DISP_NORMAL = 3'h0;
   localparam logic [2:0] DISP_CPU = 3'h1;
   localparam logic [2:0] DISP_MEM = 3'h2;
   localparam logic [2:0] DISP_CHECKSUM = 3'h3;
   localparam logic [2:0] DISP_COUNT_ALARM = 3'h4;
   // timer states, gray along the usual path
   typedef enum logic [1:0] {
      S_WAIT = 2'b00,
      S_RUN = 2'b01,
      S_DONE = 2'b11,
      S_FAULT = 2'b10
   } tstate_t;
endpackage : twin_timer_pkg

/* hdl/tick_divider.sv */
// one-cycle enable pulse at the timing unit rate
`timescale 1ns/1ps
module tick_divider
   import twin_timer_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // pulse
   output logic tick_o
);
   typedef struct packed {
      logic [31:0] cnt;   // cycles since last pulse
      logic tick;         // pulse register
   } div_t;
   div_t q, d;

   // count to the period and wrap
   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == 32'(TICK_CYC - 1)) begin
         d.cnt = 32'h0000_0000;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 32'h0000_0001;
      end
   end

   // state register
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick_o = q.tick;
endmodule : tick_divider

/* hdl/key_edge.sv */
// rising-edge pulses for a group of front panel keys
`timescale 1ns/1ps
module key_edge
   import twin_timer_pkg::*;
#(
   parameter int N = 8
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // keys
   input wire logic [N-1:0] key_i,
   output logic [N-1:0] press_o
);
   typedef struct packed {
      logic [N-1:0] prev;   // last sampled key level
   } ke_t;
   ke_t q, d;

   // keep last level
   always_comb begin
      d.prev = key_i;
   end

   // one edge gate per key, loop over keys
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_key
         assign press_o[g] = key_i[g] & ~q.prev[g];
      end
   endgenerate

   // state register
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : key_edge

/* hdl/twin_timer.sv */
// output decision, diagnostics and register slave of the twin threshold timer
//
// Behaviour
// - forecast: first output at set minus deviation
// - forecast: second output at set value
// - deviation not below set: first output at start
// - control bit picks forecast or absolute mode
// - absolute: first output at set value 1
// - absolute: second output at set value 2
// - mode key toggles shown set value in absolute mode
// - per-digit keys adjust set values while running
// - cpu fault: outputs off, reset key clears
// - ram fault: outputs off, only power clears
// - nvm fault: outputs off, reset restores defaults
// - count over alarm: alternate display, outputs kept
// - reset key hides alarm, count keeps going
// - count up: lowered set value trips output
// - count down: lowered set trips, value zeroed
// - count down: set change shifts present value
// - zero set value: output at start
// - power-up start waits 200 to 250 ms
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module twin_timer
   import twin_timer_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // field inputs
   input wire logic start_i,
   input wire logic reset_in_i,
   // front panel keys
   input wire logic reset_key_i,
   input wire logic mode_key_i,
   input wire logic [DIGIT_N-1:0] digit_key_i,
   // self test fault detectors
   input wire logic cpu_fault_i,
   input wire logic ram_fault_i,
   input wire logic nvm_fault_i,
   // loads and display
   output logic first_output_o,
   output logic second_output_o,
   output logic [VAL_W-1:0] sub_display_o,
   output logic sub_blank_o,
   output logic set1_lamp_o,
   output logic set2_lamp_o,
   output logic [2:0] disp_code_o,
   output logic checksum_indicator_o,
   output logic irq_o
);
   typedef struct packed {
      tstate_t st;                 // timer state
      logic [31:0] ctrl;           // control register
      logic [VAL_W-1:0] set1;      // set value 1 / deviation
      logic [VAL_W-1:0] set2;      // set value 2 / main set value
      logic [VAL_W-1:0] pv;        // present value
      logic [31:0] acount;         // output activation count
      logic [31:0] alarm;          // activation alarm threshold
      logic [IRQ_W-1:0] irq;       // sticky events
      logic [IRQ_W-1:0] mask;      // event mask
      logic first_output;                  // first output
      logic second_output;                  // second output
      logic show2;                 // sub display shows set value 2
      logic cpu_f;                 // latched faults
      logic ram_f;
      logic nvm_f;
      logic alarm_hide;            // alarm display suppressed
      logic [7:0] alt_cnt;         // alternation timer
      logic alt_ph;                // alternation phase
      logic [7:0] pwr_cnt;         // power-up settle timer
      logic pwr_done;              // power-up wait finished
      logic start_q;               // start input history
      logic dph;                   // bus data phase pending
      logic dwr;                   // pending phase is a write
      logic [ADDR_W-1:0] daddr;    // pending address
      logic [31:0] rdata;          // read data
      logic irq_out;               // registered interrupt
   } core_t;
   core_t q, d;

   logic tick;                     // timing unit pulse
   logic [DIGIT_N+1:0] press;      // key press pulses

   // time base
   tick_divider u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .tick_o(tick)
   );

   // key edges: digits, mode, reset
   key_edge #(.N(DIGIT_N + 2)) u_keys (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .key_i({reset_key_i, mode_key_i, digit_key_i}),
      .press_o(press)
   );

   // one unit step per set value digit, powers of ten
   function automatic logic [VAL_W-1:0] digit_step(input int k);
      logic [VAL_W-1:0] s;
      s = 24'h000001;
      for (int i = 0; i < k; i++) begin
         s = VAL_W'(s * 24'h00000A);
      end
      return s;
   endfunction : digit_step

   // all next-state logic
   always_comb begin
      logic [VAL_W-1:0] ns1;       // set values after this cycle
      logic [VAL_W-1:0] ns2;
      logic [VAL_W-1:0] elapsed;   // elapsed time in either direction
      logic [VAL_W-1:0] fc;        // forecast threshold
      logic t1;                    // threshold hits
      logic t2;
      logic fault;
      logic clr;                   // reset operation
      logic start_edge;
      logic wr;
      logic [IRQ_W-1:0] ev;
      d = q;
      ev = '0;
      wr = q.dph & q.dwr;
      clr = press[DIGIT_N+1] | reset_in_i;
      start_edge = start_i & ~q.start_q;
      d.start_q = start_i;
      ns1 = q.set1;
      ns2 = q.set2;

      // bus writes of set values
      if (wr && q.daddr == OFS_SET1) begin
         ns1 = hwdata_i[VAL_W-1:0];
      end
      if (wr && q.daddr == OFS_SET2) begin
         ns2 = hwdata_i[VAL_W-1:0];
      end
      // digit keys step the shown set value while running
      for (int k = 0; k < DIGIT_N; k++) begin
         if (press[k]) begin
            if (q.ctrl[CTRL_ABS] && !q.show2) begin
               ns1 = VAL_W'(ns1 + digit_step(k));
            end else begin
               ns2 = VAL_W'(ns2 + digit_step(k));
            end
         end
      end
      // mode key toggles the sub display in absolute mode
      if (press[DIGIT_N] && q.ctrl[CTRL_ABS]) begin
         d.show2 = ~q.show2;
      end
      if (!q.ctrl[CTRL_ABS]) begin
         d.show2 = 1'b1;
      end

      // counting down: set change moves the present value alike
      if (q.ctrl[CTRL_DOWN] && q.st == S_RUN && ns2 != q.set2) begin
         if (ns2 > q.set2) begin
            d.pv = VAL_W'(q.pv + (ns2 - q.set2));
         end else if (q.pv > q.set2 - ns2) begin
            d.pv = VAL_W'(q.pv - (q.set2 - ns2));
         end else begin
            d.pv = '0;
         end
      end
      d.set1 = ns1;
      d.set2 = ns2;

      // elapsed time and thresholds, read continuously
      elapsed = q.ctrl[CTRL_DOWN] ? VAL_W'(q.set2 - q.pv) : q.pv;
      fc = (q.set1 >= q.set2) ? '0 : VAL_W'(q.set2 - q.set1);
      if (q.ctrl[CTRL_ABS]) begin
         t1 = elapsed >= q.set1;
      end else begin
         t1 = elapsed >= fc;
      end
      t2 = q.ctrl[CTRL_DOWN] ? (q.pv == '0 || q.pv > q.set2) : (q.pv >= q.set2);

      // fault latches
      if (cpu_fault_i) begin
         d.cpu_f = 1'b1;
      end else if (press[DIGIT_N+1]) begin
         d.cpu_f = 1'b0;
      end
      if (ram_fault_i) begin
         d.ram_f = 1'b1;
      end
      if (nvm_fault_i) begin
         d.nvm_f = 1'b1;
      end else if (press[DIGIT_N+1] && q.nvm_f) begin
         d.nvm_f = 1'b0;
         d.set1 = SET1_RST;
         d.set2 = SET2_RST;
         d.ctrl = CTRL_RST;
      end
      fault = q.cpu_f | q.ram_f | q.nvm_f;

      // power-up settle wait
      if (tick && !q.pwr_done) begin
         d.pwr_cnt = q.pwr_cnt + 8'h01;
         if (q.pwr_cnt == 8'(POWERUP_TICKS - 1)) begin
            d.pwr_done = 1'b1;
         end
      end

      // timer state machine
      case (q.st)
         S_WAIT: begin
            if ((start_edge || (q.ctrl[CTRL_PWR_START] && d.pwr_done && !q.pwr_done))
                  && !clr) begin
               d.st = S_RUN;
               ev[EV_START] = 1'b1;
            end
         end
         S_RUN: begin
            if (tick) begin
               if (q.ctrl[CTRL_DOWN]) begin
                  if (q.pv != '0) begin
                     d.pv = VAL_W'(q.pv - 1'b1);
                  end
               end else if (q.pv != {VAL_W{1'b1}}) begin
                  d.pv = VAL_W'(q.pv + 1'b1);
               end
            end
            if (t1 && !q.first_output) begin
               d.first_output = 1'b1;
               ev[EV_FIRST_OUTPUT] = 1'b1;
            end
            if (t2 && !q.second_output) begin
               d.second_output = 1'b1;
               ev[EV_SECOND_OUTPUT] = 1'b1;
               d.acount = q.acount + 32'h0000_0001;
               d.st = S_DONE;
            end
         end
         S_DONE: begin
            // outputs stay on until a reset operation or a fault
            if (t1 && !q.first_output) begin
               d.first_output = 1'b1;
               ev[EV_FIRST_OUTPUT] = 1'b1;
            end
         end
         S_FAULT: begin
            if (!fault) begin
               d.st = S_WAIT;
            end
         end
         default: begin
            d.st = S_WAIT;
         end
      endcase

      // reset operation clears outputs and restarts the value
      if (clr && q.st != S_FAULT) begin
         d.st = S_WAIT;
         d.first_output = 1'b0;
         d.second_output = 1'b0;
         d.pv = q.ctrl[CTRL_DOWN] ? q.set2 : '0;
      end
      if (q.st == S_WAIT) begin
         d.pv = q.ctrl[CTRL_DOWN] ? d.set2 : '0;
      end
      // any fault forces outputs off
      if (fault || cpu_fault_i || ram_fault_i || nvm_fault_i) begin
         d.st = S_FAULT;
         d.first_output = 1'b0;
         d.second_output = 1'b0;
         if (!fault) begin
            ev[EV_FAULT] = 1'b1;
         end
      end

      // activation count alarm and its alternation
      if (q.acount > q.alarm && !(d.acount > q.alarm && q.acount <= q.alarm)) begin
         if (tick) begin
            if (q.alt_cnt == 8'(ALT_TICKS - 1)) begin
               d.alt_cnt = 8'h00;
               d.alt_ph = ~q.alt_ph;
            end else begin
               d.alt_cnt = q.alt_cnt + 8'h01;
            end
         end
      end
      if (d.acount > q.alarm && q.acount <= q.alarm) begin
         ev[EV_ALARM] = 1'b1;
      end
      if (press[DIGIT_N+1] && q.acount > q.alarm) begin
         d.alarm_hide = 1'b1;
      end

      // ahb-lite address phase capture, zero wait states
      d.dph = hsel_i & hready_i & htrans_i[1];
      d.dwr = hwrite_i;
      d.daddr = haddr_i[ADDR_W-1:0];
      if (wr) begin
         case (q.daddr)
            OFS_CTRL: d.ctrl = hwdata_i;
            OFS_MASK: d.mask = hwdata_i[IRQ_W-1:0];
            OFS_ALARM: begin
               d.alarm = hwdata_i;
               // a key press in the same cycle still hides, set wins
               d.alarm_hide = press[DIGIT_N+1] & (q.acount > q.alarm);
            end
            default: begin
            end
         endcase
      end
      // sticky events, set wins over write-one clear
      if (wr && q.daddr == OFS_IRQ) begin
         d.irq = (q.irq & ~hwdata_i[IRQ_W-1:0]) | ev;
      end else begin
         d.irq = q.irq | ev;
      end
      d.irq_out = |(d.irq & d.mask);

      // read data for the next data phase
      d.rdata = 32'h0000_0000;
      case (haddr_i[ADDR_W-1:0])
         OFS_CTRL: d.rdata = q.ctrl;
         OFS_SET1: d.rdata = {8'h00, q.set1};
         OFS_SET2: d.rdata = {8'h00, q.set2};
         OFS_PV: d.rdata = {8'h00, q.pv};
         OFS_STAT: d.rdata = {23'h000000, q.alarm_hide, q.acount > q.alarm, q.nvm_f,
                              q.ram_f, q.cpu_f, q.show2, q.st == S_RUN, q.second_output, q.first_output};
         OFS_IRQ: d.rdata = {27'h0000000, q.irq};
         OFS_MASK: d.rdata = {27'h0000000, q.mask};
         OFS_CNT: d.rdata = q.acount;
         OFS_ALARM: d.rdata = q.alarm;
         default: d.rdata = 32'h0000_0000;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.ctrl <= CTRL_RST;
         q.set1 <= SET1_RST;
         q.set2 <= SET2_RST;
         q.alarm <= ALARM_RST;
         q.show2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // display outputs, registered
   logic [VAL_W-1:0] sub_q;
   logic blank_q;
   logic lamp1_q;
   logic lamp2_q;
   logic [2:0] code_q;
   logic sum_q;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sub_q <= '0;
         blank_q <= 1'b0;
         lamp1_q <= 1'b0;
         lamp2_q <= 1'b0;
         code_q <= DISP_NORMAL;
         sum_q <= 1'b0;
      end else begin
         sub_q <= q.show2 ? q.set2 : q.set1;
         blank_q <= q.cpu_f | q.ram_f;
         lamp1_q <= q.ctrl[CTRL_ABS] & ~q.show2;
         lamp2_q <= q.ctrl[CTRL_ABS] & q.show2;
         sum_q <= q.nvm_f & ~q.cpu_f;
         if (q.cpu_f) begin
            code_q <= DISP_CPU;
         end else if (q.ram_f || q.nvm_f) begin
            code_q <= q.ram_f ? DISP_MEM : DISP_CHECKSUM;
         end else if (q.acount > q.alarm && !q.alarm_hide && q.alt_ph) begin
            code_q <= DISP_COUNT_ALARM;
         end else begin
            code_q <= DISP_NORMAL;
         end
      end
   end

   assign first_output_o = q.first_output;
   assign second_output_o = q.second_output;
   assign sub_display_o = sub_q;
   assign sub_blank_o = blank_q;
   assign set1_lamp_o = lamp1_q;
   assign set2_lamp_o = lamp2_q;
   assign disp_code_o = code_q;
   assign checksum_indicator_o = sum_q;
   assign irq_o = q.irq_out;
   assign hrdata_o = q.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
endmodule : twin_timer

/* verif/twin_timer_checker.sv */
// port assertions for the twin threshold timer
`timescale 1ns/1ps
module twin_timer_checker
   import twin_timer_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // field and fault inputs
   input wire logic reset_in_i,
   input wire logic reset_key_i,
   input wire logic cpu_fault_i,
   input wire logic ram_fault_i,
   input wire logic nvm_fault_i,
   // bus and load outputs
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic first_output_o,
   input wire logic second_output_o,
   input wire logic sub_blank_o,
   input wire logic set1_lamp_o,
   input wire logic set2_lamp_o,
   input wire logic [2:0] disp_code_o,
   input wire logic checksum_indicator_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   logic calm_now; // nothing that may clear the outputs this cycle
   logic [3:0] calm_q; // history of calm cycles, covers key edge latency
   assign calm_now = !(reset_in_i || reset_key_i || cpu_fault_i || ram_fault_i || nvm_fault_i);
   // shift calm history
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         calm_q <= 4'h0;
      end else begin
         calm_q <= {calm_q[2:0], calm_now};
      end
   end
   // faults held long enough to pass the input register
   sequence any_fault_s;
      (cpu_fault_i || ram_fault_i || nvm_fault_i) [*3];
   endsequence
   sequence ram_only_s;
      (ram_fault_i && !cpu_fault_i && !nvm_fault_i) [*3];
   endsequence
   sequence nvm_only_s;
      (nvm_fault_i && !cpu_fault_i && !ram_fault_i) [*3];
   endsequence
   ready_always_a: assert property (hreadyout_o)
      else $error("hreadyout low");
   okay_resp_a: assert property (!hresp_o)
      else $error("hresp not okay");
   fault_off_a: assert property (any_fault_s |-> !first_output_o && !second_output_o)
      else $error("output on during fault");
   cpu_code_a: assert property (cpu_fault_i [*3] |-> disp_code_o == DISP_CPU && sub_blank_o)
      else $error("cpu fault display wrong");
   ram_blank_a: assert property (ram_only_s |-> sub_blank_o && disp_code_o == DISP_MEM)
      else $error("ram fault display wrong");
   nvm_sum_a: assert property (nvm_only_s |-> checksum_indicator_o && disp_code_o == DISP_CHECKSUM)
      else $error("nvm fault display wrong");
   lamp_one_a: assert property (!(set1_lamp_o && set2_lamp_o))
      else $error("both set lamps lit");
   reset_clear_a: assert property (reset_in_i [*3] |-> !first_output_o && !second_output_o)
      else $error("output on during reset");
   hold_out_a: assert property (calm_q == 4'hF |-> $stable(first_output_o) || first_output_o)
      else $error("first output dropped");
   hold_two_a: assert property (calm_q == 4'hF && $past(second_output_o) |-> second_output_o)
      else $error("second output dropped");
endmodule : twin_timer_checker

bind twin_timer twin_timer_checker i_twin_timer_checker (.*);

/* verif/field_model.sv */
// sensors, panel keys and fault lines around the timer
`timescale 1ns/1ps
module field_model (
   // clock
   input wire logic clk_sys_i,
   // lines: 0 start,1 reset,2 reset key,3 mode key,4 cpu,5 ram,6 nvm,7+ digits
   output logic [12:0] line_o
);
   logic [12:0] line_q = 13'h0000; // all contacts open at power-up
   assign line_o = line_q;
   // change one line after an edge, then hold so the edge detector sees it
   task automatic drive(input int b, input logic v);
      @(posedge clk_sys_i);
      line_q[b] <= v;
      repeat (3) @(posedge clk_sys_i);
   endtask : drive
   // a key press is a closed contact followed by a release
   task automatic press(input int b);
      drive(b, 1'b1);
      drive(b, 1'b0);
   endtask : press
endmodule : field_model

/* verif/testbench.sv */
// self-checking bench for the twin threshold timer
`timescale 1ns/1ps
module testbench
   import twin_timer_pkg::*;
;
   localparam int START = 0, RST_IN = 1, RKEY = 2, MKEY = 3, CPU = 4, RAM = 5, NVM = 6, DIG = 7;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic [31:0] rd; // last read word
   logic hready;
   logic [12:0] line; // field lines from the model
   logic first_output, second_output, blank, lamp1, lamp2, sumi, irq;
   logic [VAL_W-1:0] shown;
   logic [2:0] code;
   int n_mismatch = 0;
   int n_checks = 0;
   int cycles = 0;
   // 200 MHz clock
   always #2.5 clk_sys_i = ~clk_sys_i;
   field_model i_field_model (.clk_sys_i(clk_sys_i), .line_o(line));
   twin_timer i_twin_timer (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
      .start_i(line[START]), .reset_in_i(line[RST_IN]), .reset_key_i(line[RKEY]),
      .mode_key_i(line[MKEY]), .digit_key_i(line[12:7]), .cpu_fault_i(line[CPU]),
      .ram_fault_i(line[RAM]), .nvm_fault_i(line[NVM]), .first_output_o(first_output),
      .second_output_o(second_output), .sub_display_o(shown), .sub_blank_o(blank),
      .set1_lamp_o(lamp1), .set2_lamp_o(lamp2), .disp_code_o(code),
      .checksum_indicator_o(sumi), .irq_o(irq));
   // verdict and end of run
   task automatic results;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   // hang guard, the whole run needs well under a thousand bus cycles
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         results();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one single word transfer, address phase then data phase
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk_sys_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h00000, a};
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk_sys_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic pause;
      repeat (4) @(posedge clk_sys_i);
   endtask : pause
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      pause();
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, e);
   endtask : rdc
   task automatic pin(input int b, input logic v);
      i_field_model.drive(b, v);
   endtask : pin
   // reset operation from the field, start line released first
   task automatic restart;
      pin(START, 1'b0);
      pin(RST_IN, 1'b1);
      pin(RST_IN, 1'b0);
   endtask : restart
   task automatic t_regs;
      rdc(OFS_CTRL, CTRL_RST);
      rdc(OFS_SET1, {8'h00, SET1_RST});
      rdc(OFS_SET2, {8'h00, SET2_RST});
      rdc(OFS_ALARM, ALARM_RST);
      wr(12'h100, 32'h0000_00FF);
      rdc(12'h100, 32'h0000_0000);
      wr(OFS_PV, 32'h0000_0055);
      rdc(OFS_PV, 32'h0000_0000);
      $display("test regs done");
   endtask : t_regs
   task automatic t_forecast;
      wr(OFS_CTRL, 32'h0000_0000);
      wr(OFS_SET2, 32'h0000_0005);
      wr(OFS_SET1, 32'h0000_0004);
      pin(START, 1'b1);
      chk(first_output, 32'h0);
      chk(second_output, 32'h0);
      restart();
      wr(OFS_SET1, 32'h0000_0006);
      pin(START, 1'b1);
      chk(first_output, 32'h1);
      wr(OFS_SET2, 32'h0000_0000);
      chk(second_output, 32'h1);
      restart();
      chk(first_output, 32'h0);
      chk(second_output, 32'h0);
      rdc(OFS_PV, 32'h0000_0000);
      $display("test forecast done");
   endtask : t_forecast
   task automatic t_absolute;
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_SET1, 32'h0000_0003);
      wr(OFS_SET2, 32'h0000_0000);
      pin(START, 1'b1);
      chk(first_output, 32'h0);
      chk(second_output, 32'h1);
      chk(lamp2, 32'h1);
      chk(shown, 32'h0000_0000);
      i_field_model.press(MKEY);
      chk(lamp1, 32'h1);
      chk(shown, 32'h0000_0003);
      i_field_model.press(DIG + 1);
      chk(shown, 32'h0000_000D);
      rdc(OFS_SET1, 32'h0000_000D);
      i_field_model.press(MKEY);
      chk(lamp2, 32'h1);
      restart();
      $display("test absolute done");
   endtask : t_absolute
   task automatic t_countdown;
      wr(OFS_CTRL, 32'h0000_0002);
      wr(OFS_SET2, 32'h0000_000A);
      pin(START, 1'b1);
      rdc(OFS_PV, 32'h0000_000A);
      wr(OFS_SET2, 32'h0000_000F);
      rdc(OFS_PV, 32'h0000_000F);
      wr(OFS_SET2, 32'h0000_0000);
      chk(second_output, 32'h1);
      rdc(OFS_PV, 32'h0000_0000);
      restart();
      $display("test countdown done");
   endtask : t_countdown
   task automatic t_alarm;
      wr(OFS_CTRL, 32'h0000_0001);
      wr(OFS_SET1, 32'h0000_0005);
      pin(START, 1'b1);
      wr(OFS_ALARM, 32'h0000_0003);
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      chk(rd[ST_ALARM], 32'h1);
      chk(second_output, 32'h1);
      i_field_model.press(RKEY);
      bus(1'b0, OFS_STAT, 32'h0000_0000);
      chk(rd[ST_ALARM_SHOW], 32'h1);
      chk(code, DISP_NORMAL);
      rdc(OFS_CNT, 32'h0000_0004);
      restart();
      $display("test alarm done");
   endtask : t_alarm
   task automatic t_faults;
      wr(OFS_MASK, 32'h0000_0000);
      wr(OFS_IRQ, 32'h0000_001F);
      pin(START, 1'b1);
      pin(CPU, 1'b1);
      chk(second_output, 32'h0);
      chk(code, DISP_CPU);
      chk(irq, 32'h0);
      wr(OFS_MASK, 32'h0000_0004);
      chk(irq, 32'h1);
      pin(CPU, 1'b0);
      i_field_model.press(RKEY);
      chk(blank, 32'h0);
      rdc(OFS_SET1, 32'h0000_0005);
      wr(OFS_IRQ, 32'h0000_0004);
      chk(irq, 32'h0);
      pin(NVM, 1'b1);
      chk(sumi, 32'h1);
      pin(NVM, 1'b0);
      i_field_model.press(RKEY);
      rdc(OFS_SET2, {8'h00, SET2_RST});
      pin(RAM, 1'b1);
      pin(RAM, 1'b0);
      i_field_model.press(RKEY);
      chk(blank, 32'h1);
      chk(code, DISP_MEM);
      rst_b_i <= 1'b0;
      repeat (6) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      pause();
      chk(blank, 32'h0);
      $display("test faults done");
   endtask : t_faults
   // main sequence
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_forecast();
      t_absolute();
      t_countdown();
      t_alarm();
      t_faults();
      results();
   end
endmodule : testbench
